// ==== core/half_key_consts.vh ====
/*
 * bit positions, widths and constants of the second-stage half keys.
 * assumes: included by the key builder files only.
 */
`ifndef HALF_KEY_CONSTS_VH
`define HALF_KEY_CONSTS_VH

// ==========================================================
// key geometry
`define KEY_W              188
`define PREFIX_W           46

// ==========================================================
// key selector codes
`define KSEL_NONE          2'h0
`define KSEL_V4_OTHER      2'h1
`define KSEL_V6_STD        2'h2
`define KSEL_OAM           2'h3

// ==========================================================
// ipv4 non-l4 key fields
`define V4_IS_IPV4_BIT     46
`define V4_FRAG_BIT        47
`define V4_LATER_FRAG_BIT  48
`define V4_OPTIONS_BIT     49
`define V4_HOPS_BIT        50
`define V4_TOS_LSB         51
`define V4_DADDR_LSB       59
`define V4_SADDR_LSB       91
`define V4_ADDR_EQ_BIT     123
`define V4_PROTO_LSB       124
`define V4_PAYLOAD_LSB     132
`define V4_MIN_HDR_WORDS   4'h5

// ==========================================================
// ipv6 standard key fields
`define V6_HOPS_BIT        46
`define V6_SADDR_LSB       47
`define V6_NEXT_HDR_LSB    175

// ==========================================================
// oam key fields
`define OAM_DMAC_LSB       46
`define OAM_SMAC_LSB       94
`define OAM_LEVEL_LSB      142
`define OAM_LEVEL_W        7
`define OAM_VERSION_FIELD_LSB        149
`define OAM_OP_LSB         154
`define OAM_FLAG_BYTE_LSB      162
`define OAM_MEP_LSB        170
`define OAM_CNTS_ZERO_BIT  186
`define OAM_ETYPE_BIT      187
`define OAM_ETHERTYPE      16'h8902

`endif

// ==== core/level_thermo.v ====
/*
 * maintenance level to thermometer code converter.
 * assumes: level is a plain binary value, purely combinational use.
 */
`include "half_key_consts.vh"

module level_thermo #(
    parameter W = `OAM_LEVEL_W
) (
    // level in
    input  wire [2:0]   maintenance_level_i,
    // thermometer out
    output reg  [W-1:0] maint_level_thermo_o
);

    // ==========================================================
    // lowest n bits set for level n
    integer i;
    always @* begin
        for (i = 0; i < W; i = i + 1) begin
            maint_level_thermo_o[i] = (i < maintenance_level_i);
        end
    end

endmodule

// ==== core/half_key_builder.v ====
/*
 * second-stage security lookup half key builder: ipv4 non-l4, ipv6
 * standard and oam keys, registered towards the match array.
 * assumes: parser fields valid in the cycle key_req_i is high; the
 * common prefix comes ready made from the first-stage classifier.
 */
`include "half_key_consts.vh"

module half_key_builder #(
    parameter KEY_W    = `KEY_W,
    parameter PREFIX_W = `PREFIX_W,
    parameter L4_W     = 64
) (
    // clock and reset
    input  wire                 core_clk_i,
    input  wire                 reset_n_i,
    // lookup request
    input  wire                 key_req_i,
    input  wire [PREFIX_W-1:0]  prefix_i,
    input  wire                 v6_std_key_en_i,
    input  wire                 is_oam_i,
    input  wire [L4_W-1:0]      l4_mask_i,
    // l3 header fields
    input  wire                 is_ipv4_i,
    input  wire                 is_ipv6_i,
    input  wire                 more_frags_i,
    input  wire [12:0]          frag_offset_i,
    input  wire [3:0]           header_len_i,
    input  wire [7:0]           ttl_i,
    input  wire [7:0]           tos_i,
    input  wire [7:0]           protocol_i,
    input  wire [127:0]         src_addr_i,
    input  wire [127:0]         dst_addr_i,
    input  wire [55:0]          post_header_bytes_i,
    // l2 and oam fields
    input  wire [47:0]          dest_mac_i,
    input  wire [47:0]          src_mac_i,
    input  wire [15:0]          ethertype_i,
    input  wire [2:0]           maintenance_level_i,
    input  wire [4:0]           oam_version_i,
    input  wire [7:0]           oam_op_i,
    input  wire [7:0]           oam_flag_byte_i,
    input  wire [15:0]          endpoint_id_i,
    input  wire [31:0]          tx_fcf_i,
    input  wire [31:0]          rx_fcb_i,
    input  wire [31:0]          tx_fcb_i,
    // key out
    output reg                  key_valid_o,
    output reg  [1:0]           key_sel_o,
    output reg  [KEY_W-1:0]     key_o,
    output reg  [L4_W-1:0]      l4_care_o
);

    // ==========================================================
    // derived frame flags
    wire        frag_offset_gt0;
    wire        fragmented_flag;
    wire        later_fragment_flag;
    wire        header_options_flag;
    wire        l4_absent;
    wire        addr_equal_flag;
    wire        use_v6_std;
    wire [`OAM_LEVEL_W-1:0] maint_level_thermo;

    assign frag_offset_gt0     = (frag_offset_i != 13'h0000);
    assign fragmented_flag     = is_ipv4_i & (more_frags_i | frag_offset_gt0);
    assign later_fragment_flag = fragmented_flag & frag_offset_gt0;
    assign header_options_flag = is_ipv4_i & (header_len_i > `V4_MIN_HDR_WORDS);
    assign l4_absent           = header_options_flag | later_fragment_flag;
    // ipv4 addresses sit in the low word, upper bits zero from the parser
    assign addr_equal_flag     = (src_addr_i == dst_addr_i);
    assign use_v6_std          = is_ipv6_i & v6_std_key_en_i;

    level_thermo #(
        .W(`OAM_LEVEL_W)
    ) u_level_thermo (
        .maintenance_level_i  (maintenance_level_i),
        .maint_level_thermo_o (maint_level_thermo)
    );

    // ==========================================================
    // key assembly
    reg [KEY_W-1:0] key_d;
    reg [1:0]       sel_d;
    reg [L4_W-1:0]  care_d;

    always @* begin
        key_d = {KEY_W{1'b0}};
        key_d[PREFIX_W-1:0] = prefix_i;
        sel_d  = `KSEL_NONE;
        care_d = l4_absent ? {L4_W{1'b0}} : l4_mask_i;
        if (is_oam_i) begin
            sel_d = `KSEL_OAM;
            key_d[`OAM_DMAC_LSB +: 48]  = dest_mac_i;
            key_d[`OAM_SMAC_LSB +: 48]  = src_mac_i;
            key_d[`OAM_LEVEL_LSB +: `OAM_LEVEL_W] = maint_level_thermo;
            key_d[`OAM_VERSION_FIELD_LSB +: 5]    = oam_version_i;
            key_d[`OAM_OP_LSB +: 8]     = oam_op_i;
            key_d[`OAM_FLAG_BYTE_LSB +: 8]  = oam_flag_byte_i;
            key_d[`OAM_MEP_LSB +: 16]   = endpoint_id_i;
            key_d[`OAM_CNTS_ZERO_BIT]   = (tx_fcf_i == 32'h00000000) &
                                          (rx_fcb_i == 32'h00000000) &
                                          (tx_fcb_i == 32'h00000000);
            key_d[`OAM_ETYPE_BIT]       = (ethertype_i == `OAM_ETHERTYPE);
        end else if (use_v6_std) begin
            sel_d = `KSEL_V6_STD;
            key_d[`V6_HOPS_BIT]           = (ttl_i != 8'h00);
            key_d[`V6_SADDR_LSB +: 128]   = src_addr_i;
            key_d[`V6_NEXT_HDR_LSB +: 8]  = protocol_i;
        end else if (is_ipv4_i | is_ipv6_i) begin
            sel_d = `KSEL_V4_OTHER;
            key_d[`V4_IS_IPV4_BIT]     = is_ipv4_i;
            key_d[`V4_FRAG_BIT]        = fragmented_flag;
            key_d[`V4_LATER_FRAG_BIT]  = later_fragment_flag;
            key_d[`V4_OPTIONS_BIT]     = header_options_flag;
            key_d[`V4_HOPS_BIT]        = (ttl_i != 8'h00);
            key_d[`V4_TOS_LSB +: 8]    = tos_i;
            if (is_ipv4_i) begin
                key_d[`V4_DADDR_LSB +: 32] = dst_addr_i[31:0];
                key_d[`V4_SADDR_LSB +: 32] = src_addr_i[31:0];
            end else begin
                key_d[`V4_DADDR_LSB +: 32] = src_addr_i[63:32];
                key_d[`V4_SADDR_LSB +: 32] = src_addr_i[31:0];
            end
            key_d[`V4_ADDR_EQ_BIT]     = addr_equal_flag;
            key_d[`V4_PROTO_LSB +: 8]  = protocol_i;
            // options are not skipped: optioned frames carry option bytes here
            key_d[`V4_PAYLOAD_LSB +: 56] = post_header_bytes_i;
        end
    end

    // ==========================================================
    // one registered transfer per lookup
    always @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            key_valid_o <= 1'b0;
            key_sel_o   <= `KSEL_NONE;
            key_o       <= {KEY_W{1'b0}};
            l4_care_o   <= {L4_W{1'b0}};
        end else begin
            key_valid_o <= key_req_i;
            if (key_req_i) begin
                key_sel_o <= sel_d;
                key_o     <= key_d;
                l4_care_o <= care_d;
            end
        end
    end

endmodule

// ==== bench/half_key_builder_monitor.sv ====
/* checker of the half key builder ports.
   assumes: bound to the builder, default key and prefix widths. */
module half_key_builder_monitor (
    // ==========
    // watched ports
    input wire logic         core_clk_i,
    input wire logic         reset_n_i,
    input wire logic         key_req_i,
    input wire logic         v6_std_key_en_i,
    input wire logic         is_oam_i,
    input wire logic         is_ipv4_i,
    input wire logic         is_ipv6_i,
    input wire logic         more_frags_i,
    input wire logic [12:0]  frag_offset_i,
    input wire logic [3:0]   header_len_i,
    input wire logic [15:0]  ethertype_i,
    input wire logic [45:0]  prefix_i,
    input wire logic [127:0] dst_addr_i,
    input wire logic         key_valid_o,
    input wire logic [1:0]   key_sel_o,
    input wire logic [187:0] key_o,
    input wire logic [63:0]  l4_care_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);
    wire v4 = key_req_i && is_ipv4_i && !is_oam_i;
    AST_ONE_PER_REQ: assert property (key_valid_o == $past(key_req_i))
        else $error("valid not one cycle after request");
    AST_PREFIX: assert property (key_req_i |=> key_o[45:0] == $past(prefix_i))
        else $error("prefix not carried");
    AST_V4_SEL: assert property (v4 |=> key_sel_o == 2'h1 && key_o[46])
        else $error("ipv4 key wrong");
    AST_FRAG: assert property (v4 |=> key_o[47] == ($past(more_frags_i) || $past(frag_offset_i) != 13'h0))
        else $error("fragment flag wrong");
    AST_LATER: assert property (v4 |=> key_o[48] == ($past(frag_offset_i) != 13'h0))
        else $error("later fragment flag wrong");
    AST_OPTS: assert property (v4 |=> key_o[49] == ($past(header_len_i) > 4'h5))
        else $error("options flag wrong");
    AST_NO_L4: assert property (v4 && (header_len_i > 4'h5 || frag_offset_i != 13'h0) |=> l4_care_o == 64'h0)
        else $error("layer-4 care not cleared");
    AST_DST: assert property (v4 |=> {96'h0, key_o[90:59]} == $past(dst_addr_i))
        else $error("destination word wrong");
    AST_V6_FALLBACK: assert property (key_req_i && is_ipv6_i && !is_oam_i && !v6_std_key_en_i |=> key_sel_o == 2'h1 && !key_o[46])
        else $error("ipv6 fallback wrong");
    AST_OAM_ETYPE: assert property (key_req_i && is_oam_i |=> key_sel_o == 2'h3 && key_o[187] == ($past(ethertype_i) == 16'h8902))
        else $error("oam ethertype flag wrong");
endmodule

// ==== bench/match_array_model.sv ====
/* match array stand-in holding one oam entry.
   assumes: one key per valid pulse, thermometer level at 148:142. */
module match_array_model (
    // ==========
    // key in, counts out
    input wire logic         core_clk_i,
    input wire logic         key_valid_i,
    input wire logic [1:0]   key_sel_i,
    input wire logic [187:0] key_i,
    output logic [7:0]       keys_o,
    output logic [7:0]       hits_o
);
    initial begin
        keys_o = 8'h00;
        hits_o = 8'h00;
    end
    always @(posedge core_clk_i) begin
        if (key_valid_i) begin
            keys_o <= keys_o + 8'h01;
            // level at or below 4: low four bits masked, upper three must be 0
            if (key_sel_i == 2'h3 && key_i[148:146] == 3'h0) begin
                hits_o <= hits_o + 8'h01;
            end
        end
    end
endmodule

// ==== bench/half_key_builder_tb_top.sv ====
/* self-checking bench of the half key builder.
   assumes: inputs driven on falling edges, answers one cycle later. */
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin fails++; $display("[ERR] %s exp %h got %h", n, e, a); end end
module half_key_builder_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // ==========
    // stimulus and results
    logic core_clk_i = 0, reset_n_i = 0, key_req_i = 0, v6_std_key_en_i = 0, is_oam_i = 0;
    logic is_ipv4_i = 0, is_ipv6_i = 0, more_frags_i = 0, key_valid_o;
    logic [45:0] prefix_i = 46'h2A5A5A5A5A5A;
    logic [63:0] l4_mask_i = '1, l4_care_o;
    logic [12:0] frag_offset_i = 0;
    logic [3:0] header_len_i = 4'h5;
    logic [2:0] maintenance_level_i = 0;
    logic [4:0] oam_version_i = 5'h15;
    logic [7:0] ttl_i = 0, tos_i = 8'hA5, protocol_i = 8'h11, oam_op_i = 8'h01, oam_flag_byte_i = 8'h81;
    logic [127:0] src_addr_i = 0, dst_addr_i = 0;
    logic [55:0] post_header_bytes_i = 56'h0102030405060B;
    logic [47:0] dest_mac_i = 48'h0180C2000030, src_mac_i = 48'h02AABBCCDDEE;
    logic [15:0] ethertype_i = 0, endpoint_id_i = 16'h1234;
    logic [31:0] tx_fcf_i = 0, rx_fcb_i = 0, tx_fcb_i = 0;
    logic [1:0] key_sel_o;
    logic [187:0] key_o;
    logic [7:0] keys, hits;
    int fails = 0, tests_run = 0, reqs = 0;
    half_key_builder i_half_key_builder (.*);
    match_array_model i_match_array_model (.core_clk_i(core_clk_i), .key_valid_i(key_valid_o),
        .key_sel_i(key_sel_o), .key_i(key_o), .keys_o(keys), .hits_o(hits));
    initial forever #2.5 core_clk_i = ~core_clk_i;
    task automatic req();
        key_req_i = 1'b1;
        reqs++;
        @(negedge core_clk_i);
        key_req_i = 1'b0;
        `CHK("valid", 1'b1, key_valid_o)
        // one idle edge so the next request never re-raises in this time step
        @(negedge core_clk_i);
        `CHK("valid_low", 1'b0, key_valid_o)
    endtask
    task automatic t_v4();
        is_ipv4_i = 1;
        header_len_i = 4'h6;
        frag_offset_i = 13'h3;
        dst_addr_i = 128'hC0A80001;
        src_addr_i = 128'hC0A80001;
        req();
        `CHK("flags", 4'hF, key_o[49:46])
        `CHK("care", 64'h0, l4_care_o)
        `CHK("tos", 9'h14A, key_o[58:50])
        `CHK("addrs", 65'h1C0A80001C0A80001, key_o[123:59])
        `CHK("proto", 8'h11, key_o[131:124])
        `CHK("payload", 56'h0102030405060B, key_o[187:132])
        {header_len_i, frag_offset_i, more_frags_i, ttl_i, dst_addr_i} = {4'h5, 13'h0, 1'b1, 8'h01, 128'hC0A80002};
        req();
        `CHK("flags2", 5'h13, key_o[50:46])
        `CHK("care2", 64'hFFFFFFFFFFFFFFFF, l4_care_o)
        `CHK("eq2", 1'b0, key_o[123])
        is_ipv4_i = 0;
    endtask
    task automatic t_v6();
        {is_ipv6_i, v6_std_key_en_i, src_addr_i} = {2'h3, 128'h20010DB8000000001122334455667788};
        dst_addr_i = src_addr_i ^ {1'b1, 127'h0};
        req();
        `CHK("v6std", {8'h11, src_addr_i, 1'b1}, key_o[182:46])
        `CHK("v6sel", 2'h2, key_sel_o)
        {v6_std_key_en_i, dst_addr_i} = {1'b0, src_addr_i};
        req();
        `CHK("v6as4", {1'b1, 64'h5566778811223344}, key_o[123:59])
        dst_addr_i[127] = 1'b1;
        req();
        `CHK("v6eq", 1'b0, key_o[123])
        is_ipv6_i = 0;
    endtask
    task automatic t_oam();
        is_oam_i = 1;
        for (int l = 0; l < 8; l++) begin
            maintenance_level_i = 3'(l);
            ethertype_i = (l % 2) ? 16'h8902 : 16'h8903;
            tx_fcb_i = 32'(l);
            req();
            `CHK("level", 7'((8'h01 << l) - 8'h01), key_o[148:142])
            `CHK("zero", l == 0, key_o[186])
            `CHK("macs", {src_mac_i, dest_mac_i}, key_o[141:46])
            `CHK("oamf", 37'h0246902035, key_o[185:149])
            `CHK("etype", 1'(l % 2), key_o[187])
            `CHK("oamsel", 2'h3, key_sel_o)
        end
        `CHK("hits", 8'h05, hits)
    endtask
    task automatic end_of_test();
        `CHK("keys", 8'(reqs), keys)
        if (fails == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (10) @(negedge core_clk_i);
        reset_n_i = 1;
        t_v4();
        t_v6();
        t_oam();
        @(negedge core_clk_i);
        end_of_test();
    end
endmodule
bind half_key_builder half_key_builder_monitor i_half_key_builder_monitor (.*);
